// ### design/sls_link_sync.sv
// link sync control: multiframe counter, phase measure, scramblers, sync and reinit
// Notes on behaviour
// - multiframe counter wraps at F*K/4 minus one
// - subclass 2 counter runs from reset release
// - subclass 2 receive sync released on boundary
// - release on boundary reports no adjustment
// - early release: flag, direction 0, count since
// - late release: flag, direction 1, count until
// - adjustment values sent in alignment bytes 1,2
// - per-lane 32-bit scrambler, 1+x^14+x^15
// - first octet, most significant bit first
// - one scramble enable for all lanes
// - descrambler recovers within two link clocks
// - subclass 0: start counter after whole group released
// - filtered sync out, combined sync in
// - receive data released at buffer offset
// - long sync request starts transmit reinit
// - receive errors assert the sync request
// - software reinit: send K or request sync
// - global reinit disable; events raise interrupt
// - configure during reset, run after release; here the registers are reset too and take writes only after release
// - leave sync phase to alignment or data
// - subclass 1 needs a system reference edge
// - receive sync low until enough K seen
// - one 32-bit word per lane per clock
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "sls_regs.svh"

module sls_link_sync #(
  parameter int LANES     = 2,
  parameter int KMIN      = 4,
  parameter int SYNC_FILT = 2
) (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst_n,
  input  wire logic [`SLS_ADDR_W-1:0] i_addr,
  input  wire logic [31:0]           i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic      [31:0]           o_rdata,
  input  wire logic                  i_sync_n,
  input  wire logic                  i_mdev_sync_n,
  input  wire logic                  i_sysref,
  output logic                       o_dev_sync_n,
  input  wire logic [LANES*32-1:0]   i_tx_data,
  output logic                       o_tx_ready,
  output logic      [LANES*32-1:0]   o_tx_data,
  output logic      [LANES*4-1:0]    o_tx_ctrl,
  input  wire logic [LANES*32-1:0]   i_rx_data,
  input  wire logic [LANES*4-1:0]    i_rx_ctrl,
  input  wire logic [LANES-1:0]      i_rx_cgs_ok,
  input  wire logic                  i_rx_frame_err,
  input  wire logic                  i_rx_lane_err,
  output logic                       o_rx_sync_n,
  output logic      [LANES*32-1:0]   o_rx_data,
  output logic                       o_rx_valid,
  output logic                       o_irq
);

  if (LANES < 1 || LANES > 8 || KMIN < 1 || KMIN > 15 || SYNC_FILT < 1 || SYNC_FILT > 8) begin : g_chk
    $error("sls_link_sync: parameter out of range");
  end

  typedef struct packed {
    logic [1:0]                   subclass;
    logic                         scr_en;
    logic                         lane_sync_en;
    logic                         reinit_dis;
    logic [7:0]                   f_m1;
    logic [4:0]                   k_m1;
    logic [7:0]                   rbd_off;
    logic                         phadj;
    logic                         adjdir;
    logic [7:0]                   adjcnt;
    logic                         dbg_phadj;
    logic                         dbg_adjdir;
    logic [7:0]                   dbg_adjcnt;
    logic [3:0]                   ev;
    logic [3:0]                   ev_en;
    logic [12:0]                  lmfc;
    logic                         sysref_q;
    logic                         sysref_seen;
    logic                         sync_q;
    sls_pkg::sls_tx_state_type    tx_st;
    logic [1:0]                   ilas_mf;
    logic [11:0]                  lowcnt;
    logic [LANES-1:0][14:0]       scr;
    logic [LANES-1:0][14:0]       dscr;
    logic [LANES-1:0][3:0]        kcnt;
    sls_pkg::sls_rx_state_type    rx_st;
    logic                         rx_rel;
    logic [LANES*32-1:0]          tx_data;
    logic [LANES*4-1:0]           tx_ctrl;
    logic [LANES*32-1:0]          rx_data;
    logic                         tx_ready;
    logic                         dev_sync_n;
    logic                         rx_sync_n;
    logic                         rx_valid;
    logic                         irq;
    logic [31:0]                  rdata;
  } sls_state_type;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // ----------------------------------------------------------------
  // per-lane scrambling and K detection
  // ----------------------------------------------------------------
  sls_state_type          s;
  sls_state_type          next_s;
  logic [LANES-1:0][14:0] scr_h;
  logic [LANES-1:0][31:0] scr_q;
  logic [LANES-1:0][14:0] dsc_h;
  logic [LANES-1:0][31:0] dsc_q;
  logic [LANES-1:0][3:0]  kcnt_nx;
  logic [LANES-1:0]       k_ok;

  // self-synchronising, so a seed mismatch with the far end heals in 15 bits
  function automatic logic [46:0] scr_word(input logic [31:0] d, input logic [14:0] seed,
                                           input logic descr);
    logic [14:0] h;
    logic [31:0] q;
    h = seed;
    q = 32'h0;
    for (int i = 31; i >= 0; i--) begin
      q[i] = d[i] ^ h[13] ^ h[14];
      h    = {h[13:0], descr ? d[i] : q[i]};
    end
    return {h, q};
  endfunction

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic lane_k;
    assign {scr_h[l], scr_q[l]} = scr_word(i_tx_data[l*32 +: 32], s.scr[l], 1'b0);
    assign {dsc_h[l], dsc_q[l]} = scr_word(i_rx_data[l*32 +: 32], s.dscr[l], 1'b1);
    assign lane_k = (i_rx_ctrl[l*4 +: 4] == 4'hf) &&
                    (i_rx_data[l*32 +: 32] == {4{`SLS_K_CHAR}});
    assign kcnt_nx[l] = !lane_k ? 4'h0 : (s.kcnt[l] == 4'hf) ? 4'hf : s.kcnt[l] + 4'h1;
    assign k_ok[l] = s.kcnt[l] >= KMIN[3:0];
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [14:0] fk;
  logic [12:0] per;
  logic [12:0] per_m1;
  logic [12:0] half;
  logic        lmfc_run;
  logic        lmfc_wrap;
  logic        sysref_rise;
  logic        sync_rise;
  logic [11:0] thr;
  logic        tx_timeout;
  logic        rx_err;
  logic        tx_sw;
  logic        rx_sw;
  logic [3:0]  ev_set;
  logic [3:0]  ev_clr;

  always_comb begin
    next_s      = s;
    fk          = 15'(({7'h0, s.f_m1} + 15'h1) * ({10'h0, s.k_m1} + 15'h1));
    per         = fk[14:2];
    per_m1      = per - 13'h1;
    half        = {1'b0, per[12:1]};
    sysref_rise = i_sysref & ~s.sysref_q;
    sync_rise   = i_sync_n & ~s.sync_q;
    thr         = ({4'h0, s.f_m1} + 12'h1) * `SLS_REINIT_FRAMES + `SLS_REINIT_OCTETS;
    tx_timeout  = !i_sync_n && (s.lowcnt + 12'h4 > thr);
    rx_err      = ~&i_rx_cgs_ok | i_rx_frame_err | i_rx_lane_err;
    tx_sw       = i_wr && i_addr == `SLS_OFF_CTRL && i_wdata[`SLS_CTRL_TXRI];
    rx_sw       = i_wr && i_addr == `SLS_OFF_CTRL && i_wdata[`SLS_CTRL_RXRI];
    ev_set      = 4'h0;
    ev_clr      = 4'h0;

    // register writes; the registers share the link reset, so layout can only be set after its release
    if (i_wr && i_addr == `SLS_OFF_CTRL) begin
      next_s.scr_en       = i_wdata[`SLS_CTRL_SCR];
      next_s.lane_sync_en = i_wdata[`SLS_CTRL_LSYNC];
      next_s.reinit_dis   = i_wdata[`SLS_CTRL_RDIS];
      next_s.subclass     = i_wdata[`SLS_CTRL_SUB_LO +: 2];
    end else if (i_wr && i_addr == `SLS_OFF_CFG) begin
      next_s.f_m1    = i_wdata[7:0];
      next_s.k_m1    = i_wdata[12:8];
      next_s.rbd_off = i_wdata[23:16];
    end else if (i_wr && i_addr == `SLS_OFF_PHADJ) begin
      next_s.phadj  = i_wdata[0];
      next_s.adjdir = i_wdata[1];
      next_s.adjcnt = i_wdata[15:8];
    end else if (i_wr && i_addr == `SLS_OFF_EVENT) begin
      ev_clr = i_wdata[3:0];
    end else if (i_wr && i_addr == `SLS_OFF_EVENT_EN) begin
      next_s.ev_en = i_wdata[3:0];
    end

    // multiframe counter
    case (s.subclass)
      2'h0:    lmfc_run = s.tx_st == sls_pkg::SLS_TX_ILAS || s.tx_st == sls_pkg::SLS_TX_DATA;
      default: lmfc_run = 1'b1;
    endcase
    lmfc_wrap = lmfc_run && s.lmfc >= per_m1;
    if (s.subclass == 2'h1 && sysref_rise) begin
      next_s.lmfc = 13'h0;
    end else if (!lmfc_run || lmfc_wrap) begin
      next_s.lmfc = 13'h0;
    end else begin
      next_s.lmfc = s.lmfc + 13'h1;
    end
    next_s.sysref_q = i_sysref;
    next_s.sync_q   = i_sync_n;
    if (sysref_rise) begin
      next_s.sysref_seen = 1'b1;
    end

    // phase of the converter's sync release against our multiframe
    if (s.subclass == 2'h2 && s.tx_st == sls_pkg::SLS_TX_CGS && sync_rise) begin
      if (s.lmfc == 13'h0) begin
        next_s.dbg_phadj  = 1'b0;
        next_s.dbg_adjdir = 1'b0;
        next_s.dbg_adjcnt = 8'h0;
      end else if (s.lmfc <= half) begin
        next_s.dbg_phadj  = 1'b1;
        next_s.dbg_adjdir = 1'b0;
        next_s.dbg_adjcnt = s.lmfc[7:0];
      end else begin
        next_s.dbg_phadj  = 1'b1;
        next_s.dbg_adjdir = 1'b1;
        next_s.dbg_adjcnt = 8'(per - s.lmfc);
      end
    end

    // sync request length in octets, saturating
    next_s.lowcnt     = i_sync_n ? 12'h0 : (s.lowcnt >= 12'hffc) ? s.lowcnt : s.lowcnt + 12'h4;
    // filtered copy stays high until the request has been seen low SYNC_FILT cycles
    next_s.dev_sync_n = i_sync_n | (s.lowcnt < 12'(4 * (SYNC_FILT - 1)));

    // transmit sequence
    case (s.tx_st)
      sls_pkg::SLS_TX_WAIT: begin
        if (!i_sync_n) begin
          next_s.tx_st = sls_pkg::SLS_TX_CGS;
        end
      end
      sls_pkg::SLS_TX_CGS: begin
        if (i_mdev_sync_n && (s.subclass != 2'h1 || s.sysref_seen) &&
            (s.subclass == 2'h0 || lmfc_wrap)) begin
          next_s.tx_st   = s.lane_sync_en ? sls_pkg::SLS_TX_ILAS : sls_pkg::SLS_TX_DATA;
          next_s.ilas_mf = 2'h0;
        end
      end
      sls_pkg::SLS_TX_ILAS: begin
        if (lmfc_wrap) begin
          next_s.ilas_mf = s.ilas_mf + 2'h1;
          if (s.ilas_mf == `SLS_ILAS_LAST_MF) begin
            next_s.tx_st = sls_pkg::SLS_TX_DATA;
          end
        end
      end
      default: begin
      end
    endcase
    if (s.tx_st == sls_pkg::SLS_TX_DATA && sync_rise && s.lowcnt + 12'h4 <= thr) begin
      ev_set[`SLS_EV_TXERR] = 1'b1;
    end
    if ((s.tx_st == sls_pkg::SLS_TX_ILAS || s.tx_st == sls_pkg::SLS_TX_DATA) && tx_timeout) begin
      ev_set[`SLS_EV_TXTO] = 1'b1;
      if (!s.reinit_dis) begin
        next_s.tx_st       = sls_pkg::SLS_TX_CGS;
        next_s.sysref_seen = sysref_rise;
      end
    end
    if (tx_sw) begin
      next_s.tx_st       = sls_pkg::SLS_TX_WAIT;
      next_s.sysref_seen = sysref_rise;
    end

    // transmit words; user data taken while o_tx_ready is high
    next_s.tx_ready = next_s.tx_st == sls_pkg::SLS_TX_DATA;
    for (int l = 0; l < LANES; l++) begin
      next_s.tx_data[l*32 +: 32] = {4{`SLS_K_CHAR}};
      next_s.tx_ctrl[l*4 +: 4]   = 4'hf;
      if (next_s.tx_st == sls_pkg::SLS_TX_ILAS) begin
        next_s.tx_data[l*32 +: 32] = 32'h0;
        next_s.tx_ctrl[l*4 +: 4]   = 4'h0;
        if (next_s.lmfc == 13'h0) begin
          next_s.tx_ctrl[l*4 + 3] = 1'b1;
          next_s.tx_data[l*32 + 24 +: 8] = next_s.ilas_mf == 2'h1 ? `SLS_Q_CHAR : `SLS_R_CHAR;
          if (next_s.ilas_mf == 2'h1) begin
            next_s.tx_data[l*32 + 8 +: 16] = {s.adjcnt, s.phadj, s.adjdir, 6'h0};
          end
        end
        if (next_s.lmfc == per_m1) begin
          next_s.tx_data[l*32 +: 8] = `SLS_A_CHAR;
          next_s.tx_ctrl[l*4]       = 1'b1;
        end
      end else if (next_s.tx_st == sls_pkg::SLS_TX_DATA) begin
        next_s.tx_ctrl[l*4 +: 4] = 4'h0;
        if (!s.tx_ready) begin
          next_s.tx_data[l*32 +: 32] = 32'h0;
        end else if (s.scr_en) begin
          next_s.tx_data[l*32 +: 32] = scr_q[l];
          next_s.scr[l]              = scr_h[l];
        end else begin
          next_s.tx_data[l*32 +: 32] = i_tx_data[l*32 +: 32];
        end
      end
    end

    // receive sync request
    next_s.kcnt = kcnt_nx;
    case (s.rx_st)
      sls_pkg::SLS_RX_REQ: begin
        if (&k_ok && (s.subclass != 2'h2 || lmfc_wrap)) begin
          next_s.rx_st = sls_pkg::SLS_RX_RUN;
        end
      end
      default: begin
        if (rx_err) begin
          ev_set[`SLS_EV_RXCGS] = ~&i_rx_cgs_ok;
          ev_set[`SLS_EV_RXALN] = i_rx_frame_err | i_rx_lane_err;
          if (!s.reinit_dis) begin
            next_s.rx_st = sls_pkg::SLS_RX_REQ;
          end
        end
      end
    endcase
    if (rx_sw) begin
      next_s.rx_st = sls_pkg::SLS_RX_REQ;
    end
    // a fresh request must see a fresh run of K words, not a count left from before
    if (s.rx_st == sls_pkg::SLS_RX_RUN && next_s.rx_st == sls_pkg::SLS_RX_REQ) begin
      next_s.kcnt = '0;
    end
    next_s.rx_sync_n = next_s.rx_st == sls_pkg::SLS_RX_RUN;
    if (next_s.rx_st == sls_pkg::SLS_RX_REQ) begin
      next_s.rx_rel = 1'b0;
    end else if (s.lmfc == {5'h0, s.rbd_off}) begin
      next_s.rx_rel = 1'b1;
    end
    // descrambler always runs so it is settled by the time data is released
    next_s.dscr     = dsc_h;
    next_s.rx_data  = s.scr_en ? dsc_q : i_rx_data;
    next_s.rx_valid = next_s.rx_rel;

    // events: a set in the clearing cycle survives
    next_s.ev  = (s.ev & ~ev_clr) | ev_set;
    next_s.irq = |(next_s.ev & s.ev_en);

    // read port: data only in the cycle after the strobe
    next_s.rdata = 32'h0;
    if (i_rd) begin
      if (i_addr == `SLS_OFF_CTRL) begin
        next_s.rdata = {27'h0, s.subclass, s.reinit_dis, s.lane_sync_en, s.scr_en};
      end else if (i_addr == `SLS_OFF_CFG) begin
        next_s.rdata = {8'h0, s.rbd_off, 3'h0, s.k_m1, s.f_m1};
      end else if (i_addr == `SLS_OFF_PHADJ) begin
        next_s.rdata = {16'h0, s.adjcnt, 6'h0, s.adjdir, s.phadj};
      end else if (i_addr == `SLS_OFF_DBG) begin
        next_s.rdata = {16'h0, s.dbg_adjcnt, 6'h0, s.dbg_adjdir, s.dbg_phadj};
      end else if (i_addr == `SLS_OFF_STATUS) begin
        next_s.rdata = {3'h0, s.lmfc, 11'h0, s.sysref_seen, s.rx_rel, s.rx_sync_n, s.tx_st};
      end else if (i_addr == `SLS_OFF_EVENT) begin
        next_s.rdata = {28'h0, s.ev};
      end else if (i_addr == `SLS_OFF_EVENT_EN) begin
        next_s.rdata = {28'h0, s.ev_en};
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s              <= '0;
      s.subclass     <= `SLS_RST_SUBCLASS;
      s.lane_sync_en <= `SLS_RST_LSYNC;
      s.f_m1         <= `SLS_RST_F_M1;
      s.k_m1         <= `SLS_RST_K_M1;
      s.tx_st        <= sls_pkg::SLS_TX_CGS;
      s.rx_st        <= sls_pkg::SLS_RX_REQ;
      s.tx_data      <= {LANES*4{`SLS_K_CHAR}};
      s.tx_ctrl      <= '1;
      s.dev_sync_n   <= 1'b1;
      // idle level of the request, so a released line gives no false edge after reset
      s.sync_q       <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign o_rdata      = s.rdata;
  assign o_dev_sync_n = s.dev_sync_n;
  assign o_tx_ready   = s.tx_ready;
  assign o_tx_data    = s.tx_data;
  assign o_tx_ctrl    = s.tx_ctrl;
  assign o_rx_sync_n  = s.rx_sync_n;
  assign o_rx_data    = s.rx_data;
  assign o_rx_valid   = s.rx_valid;
  assign o_irq        = s.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!rst_n);

  lmfc_wrap_a: assert property (
    lmfc_wrap && !(s.subclass == 2'h1 && sysref_rise) |=> s.lmfc == 13'h0)
    else $error("multiframe counter did not wrap");
  lmfc_sub2_a: assert property (
    s.subclass == 2'h2 && !lmfc_wrap ##1 s.subclass == 2'h2 |-> s.lmfc == $past(s.lmfc) + 13'h1)
    else $error("subclass 2 counter not counting");
  phase_zero_a: assert property (
    s.subclass == 2'h2 && s.tx_st == sls_pkg::SLS_TX_CGS && sync_rise && s.lmfc == 13'h0
    |=> !s.dbg_phadj)
    else $error("adjust flag set on boundary release");
  phase_early_a: assert property (
    s.subclass == 2'h2 && s.tx_st == sls_pkg::SLS_TX_CGS && sync_rise && s.lmfc != 13'h0 &&
    s.lmfc <= half |=> s.dbg_phadj && !s.dbg_adjdir && s.dbg_adjcnt == $past(s.lmfc[7:0]))
    else $error("early release measured wrong");
  phase_late_a: assert property (
    s.subclass == 2'h2 && s.tx_st == sls_pkg::SLS_TX_CGS && sync_rise && s.lmfc > half
    |=> s.dbg_phadj && s.dbg_adjdir && s.dbg_adjcnt == 8'($past(per) - $past(s.lmfc)))
    else $error("late release measured wrong");
  ilas_cfg_a: assert property (
    s.tx_st == sls_pkg::SLS_TX_ILAS && s.ilas_mf == 2'h1 && s.lmfc == 13'h0
    |-> o_tx_data[31:8] == {`SLS_Q_CHAR, s.adjcnt, s.phadj, s.adjdir, 6'h0})
    else $error("adjustment bytes missing");
  group_hold_a: assert property (
    s.tx_st == sls_pkg::SLS_TX_CGS && !i_mdev_sync_n && !tx_sw |=> s.tx_st == sls_pkg::SLS_TX_CGS)
    else $error("left sync phase before group release");
  sysref_gate_a: assert property (
    s.tx_st == sls_pkg::SLS_TX_CGS && s.subclass == 2'h1 && !s.sysref_seen && !tx_sw
    |=> s.tx_st == sls_pkg::SLS_TX_CGS)
    else $error("left sync phase without system reference");
  tx_reinit_a: assert property (
    s.tx_st == sls_pkg::SLS_TX_DATA && tx_timeout && !s.reinit_dis && !tx_sw
    |=> s.tx_st == sls_pkg::SLS_TX_CGS ##1 o_tx_ctrl[3:0] == 4'hf)
    else $error("long sync request ignored");
  rx_hold_a: assert property (
    s.rx_st == sls_pkg::SLS_RX_REQ && !(&k_ok) |=> !o_rx_sync_n)
    else $error("receive sync released too early");
  rx_err_a: assert property (
    s.rx_st == sls_pkg::SLS_RX_RUN && rx_err && !s.reinit_dis |=> !o_rx_sync_n [*2])
    else $error("receive error did not request sync");

  ilas_seen_c: cover property (s.tx_st == sls_pkg::SLS_TX_ILAS ##1 s.tx_st == sls_pkg::SLS_TX_DATA);
  phase_late_c: cover property (s.tx_st == sls_pkg::SLS_TX_CGS && sync_rise && s.lmfc > half);
  rx_release_c: cover property (!o_rx_sync_n ##1 o_rx_sync_n ##[1:64] o_rx_valid);
  tx_reinit_c: cover property (s.tx_st == sls_pkg::SLS_TX_DATA && tx_timeout);

endmodule

// ### design/sls_pkg.sv
// state types of the link sync control
package sls_pkg;
  typedef enum logic [1:0] {
    SLS_TX_CGS  = 2'b00,
    SLS_TX_ILAS = 2'b01,
    SLS_TX_DATA = 2'b10,
    SLS_TX_WAIT = 2'b11
  } sls_tx_state_type;
  typedef enum logic {
    SLS_RX_REQ = 1'b0,
    SLS_RX_RUN = 1'b1
  } sls_rx_state_type;
endpackage

// ### design/sls_regs.svh
// register offsets, field positions, reset values and counts of the link sync control
`ifndef SLS_REGS_SVH
`define SLS_REGS_SVH

// ----------------------------------------------------------------
// register offsets (word index on the register port)
// ----------------------------------------------------------------
`define SLS_ADDR_W        3
`define SLS_OFF_CTRL      3'h0
`define SLS_OFF_CFG       3'h1
`define SLS_OFF_PHADJ     3'h2
`define SLS_OFF_DBG       3'h3
`define SLS_OFF_STATUS    3'h4
`define SLS_OFF_EVENT     3'h5
`define SLS_OFF_EVENT_EN  3'h6

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SLS_CTRL_SCR      0
`define SLS_CTRL_LSYNC    1
`define SLS_CTRL_RDIS     2
`define SLS_CTRL_SUB_LO   3
`define SLS_CTRL_TXRI     8
`define SLS_CTRL_RXRI     9
`define SLS_EV_TXTO       0
`define SLS_EV_RXCGS      1
`define SLS_EV_RXALN      2
`define SLS_EV_TXERR      3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SLS_RST_SUBCLASS  2'h1
`define SLS_RST_LSYNC     1'h1
`define SLS_RST_F_M1      8'h01
`define SLS_RST_K_M1      5'h0f

// ----------------------------------------------------------------
// control characters and counts
// ----------------------------------------------------------------
`define SLS_K_CHAR        8'hbc
`define SLS_R_CHAR        8'h1c
`define SLS_Q_CHAR        8'h9c
`define SLS_A_CHAR        8'h7c
`define SLS_REINIT_FRAMES 12'h005
`define SLS_REINIT_OCTETS 12'h009
`define SLS_ILAS_LAST_MF  2'h3

`endif

// ### testbench/sls_conv_model.sv
// converter-side lane model: K words during sync, looped lane data afterwards
`timescale 1ns/1ps
module sls_conv_model (
  input  wire logic        i_clk,
  input  wire logic        i_send_k,
  input  wire logic        i_loop,
  input  wire logic [63:0] i_tx_data,
  output logic      [63:0] o_rx_data,
  output logic      [7:0]  o_rx_ctrl,
  output logic      [1:0]  o_rx_cgs_ok
);
  // ----------------------------------------------------------------
  // lane drive
  // ----------------------------------------------------------------
  // lanes keep code group sync; error flags are driven by the bench instead
  assign o_rx_cgs_ok = 2'h3;
  initial begin
    o_rx_data = 64'h0;
    o_rx_ctrl = 8'h0;
  end
  // an idle lane toggles every word so a stale value never passes for data
  always @(posedge i_clk) begin
    o_rx_ctrl <= i_send_k ? 8'hff : 8'h00;
    if (i_send_k)
      o_rx_data <= {8{8'hbc}};
    else if (i_loop)
      o_rx_data <= i_tx_data;
    else
      o_rx_data <= ~o_rx_data;
  end
endmodule

// ### testbench/tb.sv
// self-checking bench of the link sync control
`timescale 1ns/1ps
module tb;
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0, sync_n = 0, lpb = 0;
  logic        sref = 0, sendk = 0, lp = 0, frm = 0, lne = 0;
  logic [2:0]  addr = 3'h0;
  logic [31:0] wd = 32'h0, v, rdat;
  logic [63:0] txd = 64'ha5c3e18711223344, rxd, otx, orx;
  logic [7:0]  rxc, otc;
  logic [1:0]  cok;
  logic        devs, rxs, rdy, rxv, irq;
  logic [15:0] phs [8];
  int          fail_count = 0, check_count = 0, n, c, i0 = 0;

  // subclass 1 loops the filtered sync back; low holds the group unreleased
  sls_link_sync u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wd),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_sync_n(sync_n), .i_mdev_sync_n(lpb & devs),
    .i_sysref(sref), .o_dev_sync_n(devs), .i_tx_data(txd), .o_tx_ready(rdy),
    .o_tx_data(otx), .o_tx_ctrl(otc), .i_rx_data(rxd), .i_rx_ctrl(rxc), .i_rx_cgs_ok(cok),
    .i_rx_frame_err(frm), .i_rx_lane_err(lne), .o_rx_sync_n(rxs), .o_rx_data(orx),
    .o_rx_valid(rxv), .o_irq(irq));
  sls_conv_model u_conv (.i_clk(clk), .i_send_k(sendk), .i_loop(lp), .i_tx_data(otx),
    .o_rx_data(rxd), .o_rx_ctrl(rxc), .o_rx_cgs_ok(cok));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic final_report;
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic lim;
    if (n >= 60) begin
      fail_count++;
      $display("Error at %0t ns: wait ran out", $time);
      final_report;
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [2:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdat;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial forever #50 clk = ~clk;
  initial begin
    repeat (2) @(negedge clk);
    chk({devs, rxs, rdy, irq}, 4'h8);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rreg(3'h0, v);
    chk(v, 32'h0000000a);
    rreg(3'h1, v);
    chk(v, 32'h00000f01);
    wreg(3'h7, 32'hffffffff);
    rreg(3'h7, v);
    chk(v, 32'h0);
    @(posedge clk);
    sendk <= 1'b1;
    repeat (3) @(negedge clk);
    chk(rxs, 1'b0);
    for (n = 0; n < 60 && rxs !== 1'b1; n++) @(negedge clk);
    lim;
    for (n = 0; n < 60 && rxv !== 1'b1; n++) @(negedge clk);
    lim;
    // nine cycles a pass moves the release one count along the multiframe
    wreg(3'h0, 32'h00000012);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      sync_n <= 1'b0;
      repeat (4) @(negedge clk);
      chk(devs, 1'b0);
      @(posedge clk);
      sync_n <= 1'b1;
      repeat (2) @(posedge clk);
      rreg(3'h3, v);
      phs[i] = v[15:0] & 16'hff03;
      if (v[0] === 1'b0)
        i0 = i;
    end
    for (int i = 0; i < 8; i++) begin
      c = (i - i0 + 8) % 8;
      chk(phs[i][0] ? phs[i] : 16'h0, c == 0 ? 16'h0 :
          c <= 4 ? {8'(c), 8'h01} : {8'(8 - c), 8'h03});
    end
    wreg(3'h2, 32'h00000503);
    wreg(3'h0, 32'h0000000a);
    lpb <= 1'b1;
    repeat (20) @(posedge clk);
    rreg(3'h4, v);
    chk(v[1:0], 2'h0);
    @(posedge clk);
    sref <= 1'b1;
    @(posedge clk);
    sref <= 1'b0;
    for (n = 0; n < 60 && {otc[3], otx[31:0]} !== 33'h11c000000; n++) @(negedge clk);
    lim;
    repeat (8) @(negedge clk);
    chk({otc[3], otx[31:0]}, 33'h19c05c000);
    for (n = 0; n < 60 && rdy !== 1'b1; n++) @(negedge clk);
    lim;
    repeat (3) @(negedge clk);
    chk(otx, txd);
    @(posedge clk);
    sendk <= 1'b0;
    lp <= 1'b1;
    wreg(3'h0, 32'h0000000b);
    repeat (8) @(negedge clk);
    chk(orx, txd);
    chk(otx == txd, 1'b0);
    wreg(3'h6, 32'h1);
    wreg(3'h5, 32'hf);
    sync_n <= 1'b0;
    rreg(3'h4, v);
    chk(v[1:0], 2'h2);
    for (n = 0; n < 60 && irq !== 1'b1; n++) @(negedge clk);
    lim;
    rreg(3'h4, v);
    chk(v[1:0], 2'h0);
    wreg(3'h5, 32'h1);
    sync_n <= 1'b1;
    @(negedge clk);
    chk(irq, 1'b0);
    wreg(3'h0, 32'h0000010b);
    rreg(3'h4, v);
    chk({otc, v[1:0]}, 10'h3ff);
    @(posedge clk);
    sync_n <= 1'b0;
    sendk <= 1'b1;
    rreg(3'h4, v);
    chk(v[1:0], 2'h0);
    wreg(3'h0, 32'h0000020b);
    @(negedge clk);
    chk(rxs, 1'b0);
    for (n = 0; n < 60 && rxs !== 1'b1; n++) @(negedge clk);
    lim;
    @(posedge clk);
    frm <= 1'b1;
    repeat (2) @(negedge clk);
    chk(rxs, 1'b0);
    @(posedge clk);
    frm <= 1'b0;
    for (n = 0; n < 60 && rxs !== 1'b1; n++) @(negedge clk);
    lim;
    wreg(3'h0, 32'h0000000e);
    lne <= 1'b1;
    repeat (2) @(negedge clk);
    chk(rxs, 1'b1);
    wreg(3'h0, 32'h0000000a);
    repeat (2) @(negedge clk);
    chk(rxs, 1'b0);
    final_report;
  end
endmodule
